// ---- core/ssps_consts.svh ----
// constants for the sensor serial port slave
`ifndef SSPS_CONSTS_SVH
`define SSPS_CONSTS_SVH

// byte layout on the serial lines
`define SSPS_BYTE_W 8
`define SSPS_DIR_BIT 7
`define SSPS_ADDR_W 7
`define SSPS_LAST_BIT 3'h7

// direction bit values in the address byte
`define SSPS_DIR_WRITE 1'h1
`define SSPS_DIR_READ 1'h0

// addresses that open a burst
`define SSPS_MOTION_BURST_ADDR 7'h50
`define SSPS_FW_LOAD_ADDR 7'h60
`define SSPS_PIXEL_BURST_ADDR 7'h40

// synchroniser depth and pin slots
`define SSPS_SYNC_STAGES 3
`define SSPS_PIN_N 5
`define SSPS_PIN_SCLK 0
`define SSPS_PIN_MOSI 1
`define SSPS_PIN_CS_N 2
`define SSPS_PIN_PD_N 3
`define SSPS_PIN_RST 4

// pin reset levels: clock high, select high, powered, not in reset
`define SSPS_PIN_RESET_LVL 5'h0d

// reset values
`define SSPS_BYTE_RESET 8'h00
`define SSPS_ADDR_RESET 7'h00

`endif

// ---- core/ssps_pkg.sv ----
// types for the sensor serial port slave
package ssps_pkg;

  // port sequencer states, gray along idle-address-data-burst
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ADDR  = 2'b01,
    ST_DATA  = 2'b11,
    ST_BURST = 2'b10
  } ssps_state_t;

endpackage

// ---- core/ssps_pin_if.sv ----
// carrier for synchronised pin levels and clock edges
`timescale 1ns/1ps
interface ssps_pin_if;
  logic sclk_rise; // one-cycle pulse, serial clock rose
  logic sclk_fall; // one-cycle pulse, serial clock fell
  logic mosi; // filtered serial input level
  logic cs_n; // filtered select level, active low
  logic pd_n; // filtered power-down level, active low
  logic chip_rst; // filtered device reset level, active high

  // synchroniser side
  modport src (
    output sclk_rise, sclk_fall, mosi, cs_n, pd_n, chip_rst
  );

  // port logic side
  modport dst (
    input sclk_rise, sclk_fall, mosi, cs_n, pd_n, chip_rst
  );
endinterface

// ---- core/ssps_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`include "ssps_consts.svh"
module ssps_pin_sync #(
  parameter int PIN_N = `SSPS_PIN_N
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // raw pins
  input wire logic [PIN_N-1:0] i_pins,
  // filtered results
  ssps_pin_if.src pins
);

  logic [PIN_N-1:0] s1_q; // first stage, read only by second
  logic [PIN_N-1:0] s2_q; // second stage
  logic [PIN_N-1:0] s3_q; // third stage
  logic [PIN_N-1:0] lvl_q; // accepted level
  logic [PIN_N-1:0] lvl_d; // next accepted level
  logic rise_q; // clock rise pulse
  logic fall_q; // clock fall pulse
  localparam logic [PIN_N-1:0] RESET_LVL = `SSPS_PIN_RESET_LVL; // pin levels held in reset

  // per pin: three stage flops and a level flop, accept a change once stages two and three agree
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        s1_q[g] <= RESET_LVL[g];
        s2_q[g] <= RESET_LVL[g];
        s3_q[g] <= RESET_LVL[g];
        lvl_q[g] <= RESET_LVL[g];
      end else begin
        s1_q[g] <= i_pins[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        lvl_q[g] <= lvl_d[g];
      end
    end
    // agreement filter
    assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
  end

  // serial clock edge pulses from the accepted level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= lvl_d[`SSPS_PIN_SCLK] & ~lvl_q[`SSPS_PIN_SCLK];
      fall_q <= ~lvl_d[`SSPS_PIN_SCLK] & lvl_q[`SSPS_PIN_SCLK];
    end
  end

  // drive the carrier
  assign pins.sclk_rise = rise_q;
  assign pins.sclk_fall = fall_q;
  assign pins.mosi = lvl_q[`SSPS_PIN_MOSI];
  assign pins.cs_n = lvl_q[`SSPS_PIN_CS_N];
  assign pins.pd_n = lvl_q[`SSPS_PIN_PD_N];
  assign pins.chip_rst = lvl_q[`SSPS_PIN_RST];

endmodule

// ---- core/ssps_top.sv ----
// four-wire serial slave port of the motion sensor
// Operation
// - only the master starts any transfer
// - port idle in power-down or reset
// - select high: ignore inputs, output released
// - port wakes only after select low
// - select rise aborts transaction, back idle
// - burst ends only by raising select, power-down or chip reset
// - write: address byte top bit 1, data
// - sample serial input on clock rise
// - read: address top bit 0, device answers
// - output bit changes on clock fall
// - output bit holds until next fall
`timescale 1ns/1ps
`include "ssps_consts.svh"
module ssps_top #(
  parameter logic [`SSPS_ADDR_W-1:0] MOTION_BURST_ADDR = `SSPS_MOTION_BURST_ADDR,
  parameter logic [`SSPS_ADDR_W-1:0] FW_LOAD_ADDR = `SSPS_FW_LOAD_ADDR,
  parameter logic [`SSPS_ADDR_W-1:0] PIXEL_BURST_ADDR = `SSPS_PIXEL_BURST_ADDR
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // serial pins from the master
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_cs_n,
  // device control pins
  input wire logic i_power_down_low,
  input wire logic i_chip_reset,
  // serial output pin, three signals
  output logic o_miso,
  output logic o_miso_oe_n,
  input wire logic i_miso,
  // register side towards the core
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [`SSPS_ADDR_W-1:0] o_addr,
  output logic [`SSPS_BYTE_W-1:0] o_wr_data,
  input wire logic [`SSPS_BYTE_W-1:0] i_rd_data,
  // burst status
  output logic o_burst,
  output logic o_port_active
);

  logic rst_meta_q; // reset release stage one
  logic rst_n_q; // released reset for the block
  ssps_pin_if pins (); // synchronised pins
  ssps_pkg::ssps_state_t state_q; // sequencer state
  logic port_en; // port may run
  logic [2:0] bit_q; // bit count in the byte
  logic [`SSPS_BYTE_W-1:0] rx_q; // incoming shift register
  logic [`SSPS_BYTE_W-1:0] rx_d; // incoming byte after this bit
  logic [`SSPS_BYTE_W-1:0] tx_q; // outgoing shift register
  logic dir_q; // direction of current command
  logic [`SSPS_ADDR_W-1:0] addr_q; // captured address
  logic load_q; // read data arrives this cycle
  logic byte_done; // eighth rising edge of a byte
  logic is_burst_addr; // address opens a burst
  logic wr_stb_q; // write strobe flop
  logic rd_stb_q; // read strobe flop
  logic [`SSPS_BYTE_W-1:0] wr_data_q; // write data flop
  logic miso_q; // output bit flop
  logic oe_n_q; // output enable flop
  logic active_q; // port active flop

  // i_miso is the pad readback; the slave does not use it
  logic unused_miso;
  assign unused_miso = i_miso;

  // reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // hold both stages low
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      // shift a one through
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // pin synchroniser, clock sampled as ordinary input
  ssps_pin_sync #(
    .PIN_N(`SSPS_PIN_N)
  ) u_sync (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n_q),
    .i_pins({i_chip_reset, i_power_down_low, i_cs_n, i_mosi, i_sclk}),
    .pins(pins)
  );

  // power-down and reset hold the port idle
  // enabled only once select is low
  assign port_en = ~pins.cs_n & pins.pd_n & ~pins.chip_rst;

  // msb first: new bit enters at the bottom
  assign rx_d = {rx_q[`SSPS_BYTE_W-2:0], pins.mosi};

  // a bit is taken on each clock rise
  assign byte_done = pins.sclk_rise && (bit_q == `SSPS_LAST_BIT);

  // burst addresses for the open command
  assign is_burst_addr = (dir_q == `SSPS_DIR_READ) ?
    (addr_q == MOTION_BURST_ADDR || addr_q == PIXEL_BURST_ADDR) :
    (addr_q == FW_LOAD_ADDR);

  // sequencer: idle, address byte, data byte, burst bytes
  // apart from leaving idle on select low and dropping to idle when the port is disabled, nothing happens without clock edges from the master
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // power-on: idle
      state_q <= ssps_pkg::ST_IDLE;
    end else if (!port_en) begin
      // select rise drops the whole transaction
      state_q <= ssps_pkg::ST_IDLE;
    end else begin
      // only steps while the port is enabled
      case (state_q)
        ssps_pkg::ST_IDLE: begin
          // select low opens the address phase
          state_q <= ssps_pkg::ST_ADDR;
        end
        ssps_pkg::ST_ADDR: begin
          if (byte_done) begin
            // eighth address bit seen
            state_q <= ssps_pkg::ST_DATA;
          end
        end
        ssps_pkg::ST_DATA: begin
          if (byte_done) begin
            state_q <= is_burst_addr ? ssps_pkg::ST_BURST : ssps_pkg::ST_ADDR;
          end
        end
        ssps_pkg::ST_BURST: begin
          // no new command while in burst
          state_q <= ssps_pkg::ST_BURST;
        end
        default: begin
          // unused code: recover to idle
          state_q <= ssps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // bit counter and input shift register
  // eight clocks per byte
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // counter and shifter clear
      bit_q <= 3'h0;
      rx_q <= `SSPS_BYTE_RESET;
    end else if (!port_en || state_q == ssps_pkg::ST_IDLE) begin
      bit_q <= 3'h0;
      rx_q <= `SSPS_BYTE_RESET;
    end else if (pins.sclk_rise) begin
      bit_q <= bit_q + 3'h1;
      rx_q <= rx_d;
    end
  end

  // address byte decode: direction bit and register address
  // top bit one means write
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // read of address zero until a command arrives
      dir_q <= `SSPS_DIR_READ;
      addr_q <= `SSPS_ADDR_RESET;
    end else if (port_en && state_q == ssps_pkg::ST_ADDR && byte_done) begin
      // eighth rise of the address byte
      dir_q <= rx_d[`SSPS_DIR_BIT];
      addr_q <= rx_d[`SSPS_ADDR_W-1:0];
    end
  end

  // write strobe after the data byte, also each byte of a write burst
  // an aborted write never strobes
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // no strobe out of reset
      wr_stb_q <= 1'b0;
      wr_data_q <= `SSPS_BYTE_RESET;
    end else begin
      // data byte or burst byte finished
      wr_stb_q <= port_en && byte_done && dir_q == `SSPS_DIR_WRITE &&
        (state_q == ssps_pkg::ST_DATA || state_q == ssps_pkg::ST_BURST);
      // data kept until the next data byte, never an address byte
      if (port_en && byte_done && dir_q == `SSPS_DIR_WRITE &&
          (state_q == ssps_pkg::ST_DATA || state_q == ssps_pkg::ST_BURST)) begin
        wr_data_q <= rx_d;
      end
    end
  end

  // read strobe: after a read address, and per byte in a read burst
  // device fetches the byte it will drive
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // no strobe out of reset
      rd_stb_q <= 1'b0;
    end else if (!port_en || !byte_done) begin
      // strobes only at the end of a byte
      rd_stb_q <= 1'b0;
    end else if (state_q == ssps_pkg::ST_ADDR) begin
      // address byte done, read when top bit clear
      rd_stb_q <= (rx_d[`SSPS_DIR_BIT] == `SSPS_DIR_READ);
    end else if (dir_q == `SSPS_DIR_READ) begin
      // next byte of a read burst
      rd_stb_q <= (state_q == ssps_pkg::ST_BURST) ||
        (state_q == ssps_pkg::ST_DATA && is_burst_addr);
    end else begin
      // write data bytes never fetch
      rd_stb_q <= 1'b0;
    end
  end

  // core answers the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // nothing to load out of reset
      load_q <= 1'b0;
    end else begin
      // one cycle behind the strobe
      load_q <= rd_stb_q;
    end
  end

  // output shift register and output bit
  // output changes on clock fall
  // bit held until the next fall
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // output low out of reset
      tx_q <= `SSPS_BYTE_RESET;
      miso_q <= 1'b0;
    end else if (!port_en) begin
      // deselected: shifter cleared
      tx_q <= `SSPS_BYTE_RESET;
      miso_q <= 1'b0;
    end else if (load_q) begin
      // byte from the core, msb waits for the next fall
      tx_q <= i_rd_data;
    end else if (pins.sclk_fall && dir_q == `SSPS_DIR_READ &&
                 (state_q == ssps_pkg::ST_DATA || state_q == ssps_pkg::ST_BURST)) begin
      miso_q <= tx_q[`SSPS_BYTE_W-1];
      tx_q <= {tx_q[`SSPS_BYTE_W-2:0], 1'b0};
    end
  end

  // output enable: driven only while the port is selected
  // released whenever select is high
  // clock is never driven, only the data output
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // released out of reset
      oe_n_q <= 1'b1;
      active_q <= 1'b0;
    end else begin
      // follows the enable one cycle later
      oe_n_q <= ~port_en;
      active_q <= port_en;
    end
  end

  // outputs straight from flops
  // so the core and the pad never see a combinational glitch
  assign o_miso = miso_q;
  assign o_miso_oe_n = oe_n_q;
  assign o_wr_stb = wr_stb_q;
  assign o_rd_stb = rd_stb_q;
  assign o_addr = addr_q;
  assign o_wr_data = wr_data_q;
  assign o_port_active = active_q;

  // burst flag from the state register
  logic burst_q;
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // no burst out of reset
      burst_q <= 1'b0;
    end else begin
      // set with the byte that opens the burst
      burst_q <= port_en && (state_q == ssps_pkg::ST_BURST ||
        (state_q == ssps_pkg::ST_DATA && byte_done && is_burst_addr));
    end
  end
  assign o_burst = burst_q;

endmodule

// ---- verif/ssps_top_sva.sv ----
// pin-level checker for the sensor serial port slave
`timescale 1ns/1ps
module ssps_top_chk (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // pins in
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_power_down_low,
  input wire logic i_chip_reset,
  // outputs watched
  input wire logic o_miso,
  input wire logic o_miso_oe_n,
  input wire logic o_wr_stb,
  input wire logic o_rd_stb,
  input wire logic [6:0] o_addr,
  input wire logic o_burst,
  input wire logic o_port_active
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  // select held high past the synchroniser
  sequence cs_idle_s;
    i_cs_n [*8];
  endsequence
  // output enabled and selected for a while, then a bit change
  sequence miso_step_s;
    (!o_miso_oe_n && !i_cs_n) [*4] ##0 $changed(o_miso);
  endsequence
  oe_released_a: assert property (cs_idle_s |-> o_miso_oe_n && !o_port_active)
    else $error("miso driven while deselected");
  abort_idle_a: assert property (cs_idle_s |-> !o_burst && !o_wr_stb && !o_rd_stb)
    else $error("port busy after select rose");
  pd_gate_a: assert property ((!i_power_down_low) [*8] |-> !o_port_active && !o_wr_stb)
    else $error("port active in power down");
  rst_gate_a: assert property (i_chip_reset [*8] |-> !o_port_active && !o_rd_stb)
    else $error("port active in chip reset");
  wake_cs_a: assert property ($rose(o_port_active) |-> !i_cs_n && !$past(i_cs_n, 2))
    else $error("port woke without select");
  miso_edge_a: assert property (miso_step_s |-> !i_sclk)
    else $error("miso changed while clock high");
  wr_pulse_a: assert property (o_wr_stb |-> !o_rd_stb ##1 !o_wr_stb)
    else $error("write strobe not single");
  rd_pulse_a: assert property (o_rd_stb |=> !o_rd_stb && $stable(o_addr))
    else $error("read strobe not single");
  burst_end_a: assert property ($fell(o_burst) |-> i_cs_n)
    else $error("burst ended without select");
endmodule
bind ssps_top ssps_top_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_power_down_low(i_power_down_low), .i_chip_reset(i_chip_reset), .o_miso(o_miso),
  .o_miso_oe_n(o_miso_oe_n), .o_wr_stb(o_wr_stb), .o_rd_stb(o_rd_stb), .o_addr(o_addr),
  .o_burst(o_burst), .o_port_active(o_port_active)
);

// ---- verif/ssps_master_model.sv ----
// serial master model driving the sensor port
`timescale 1ns/1ps
module ssps_master_model (
  // clock
  input wire logic i_clk,
  // serial pins
  output logic o_sclk,
  output logic o_mosi,
  output logic o_cs_n,
  input wire logic i_miso
);
  localparam int HALF = 6; // clocks per serial half period
  // idle levels: clock high, deselected
  initial begin
    o_sclk = 1'h1;
    o_mosi = 1'h1;
    o_cs_n = 1'h1;
  end
  // wait system clocks
  task automatic pause(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic sel();
    @(posedge i_clk);
    o_cs_n <= 1'h0;
    pause(HALF);
  endtask
  // select high, gap before next frame
  task automatic desel();
    pause(HALF);
    o_cs_n <= 1'h1;
    pause(5000);
  endtask
  // clock bits msb first, sample at rise
  task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      o_sclk <= 1'h0;
      o_mosi <= tx[7-i];
      pause(HALF);
      rx[7-i] = i_miso;
      o_sclk <= 1'h1;
      // high phase alternates 6 and 7 clocks, 125 ns period on average
      pause(HALF + (i % 2));
    end
    o_mosi <= ~o_mosi;
  endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the sensor serial port slave
`timescale 1ns/1ps
`include "ssps_consts.svh"
module testbench;
  logic ref_clk = 1'h0; // system clock
  logic reset_n = 1'h0; // reset, active low
  logic pd_n = 1'h1; // power-down pin, low stops port
  logic chip_rst = 1'h0; // device reset pin
  logic [7:0] rd_data = 8'h00; // core answer byte
  logic [3:0] rd_cnt = 4'h0; // reads served by core
  logic [3:0] exp_cnt = 4'h0; // reads the bench expects
  logic [14:0] wr_seen = 15'h0000; // write strobes seen
  logic [14:0] wr_last = 15'h0000; // address and data of last write
  logic sclk, mosi, cs_n, miso, miso_oe_n, miso_w, wr_stb, rd_stb, burst, active;
  logic [6:0] addr;
  logic [7:0] wr_data;
  int miscompares = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  // released line shows the inverse level
  assign miso_w = miso_oe_n ? ~miso : miso;
  ssps_master_model i_master (.i_clk(ref_clk), .o_sclk(sclk), .o_mosi(mosi),
    .o_cs_n(cs_n), .i_miso(miso_w));
  ssps_top i_dut (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_sclk(sclk), .i_mosi(mosi),
    .i_cs_n(cs_n), .i_power_down_low(pd_n), .i_chip_reset(chip_rst), .o_miso(miso),
    .o_miso_oe_n(miso_oe_n), .i_miso(miso_w), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
    .o_addr(addr), .o_wr_data(wr_data), .i_rd_data(rd_data), .o_burst(burst),
    .o_port_active(active));
  // core model: fresh byte per read, log writes
  always @(posedge ref_clk) begin
    if (rd_stb === 1'h1) begin
      rd_data <= {rd_cnt, addr[3:0]};
      rd_cnt <= rd_cnt + 4'h1;
    end
    if (wr_stb === 1'h1) begin
      wr_seen <= wr_seen + 15'h0001;
      wr_last <= {addr, wr_data};
    end
  end
  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // clocking while deselected, powered down or in reset
  task automatic t_gated();
    logic [7:0] rx;
    logic [14:0] n;
    for (int c = 0; c < 3; c++) begin
      n = wr_seen;
      @(posedge ref_clk);
      pd_n <= (c != 1);
      chip_rst <= (c == 2);
      i_master.pause(10);
      if (c != 0) begin
        i_master.sel();
      end
      i_master.shift(8, 8'h95, rx);
      i_master.shift(8, 8'h3c, rx);
      check("gated active", 15'h0000, {14'h0000, active});
      i_master.desel();
      check("gated write", n, wr_seen);
      pd_n <= 1'h1;
      chip_rst <= 1'h0;
    end
    $display("test gated done");
  endtask
  // two-byte write
  task automatic t_write(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    logic [14:0] n;
    n = wr_seen;
    i_master.sel();
    i_master.shift(8, {`SSPS_DIR_WRITE, a}, rx);
    i_master.shift(8, d, rx);
    i_master.desel();
    check("write count", n + 15'h0001, wr_seen);
    check("write word", {a, d}, wr_last);
    $display("test write done");
  endtask
  // read of nb bytes, burst or ordinary
  task automatic t_read(input logic [6:0] a, input int gap, input int nb, input logic b);
    logic [7:0] rx;
    logic [14:0] n;
    n = wr_seen;
    i_master.sel();
    i_master.shift(8, {`SSPS_DIR_READ, a}, rx);
    i_master.pause(gap);
    for (int k = 0; k < nb; k++) begin
      i_master.shift(8, 8'hff, rx);
      check("read byte", {7'h00, exp_cnt, a[3:0]}, {7'h00, rx});
      exp_cnt++;
    end
    exp_cnt = exp_cnt + {3'h0, b};
    check("burst flag", {14'h0000, b}, {14'h0000, burst});
    check("read drive", 15'h0000, {14'h0000, miso_oe_n});
    i_master.desel();
    check("burst end", 15'h0000, {14'h0000, burst});
    check("read release", 15'h0001, {14'h0000, miso_oe_n});
    check("read write", n, wr_seen);
    $display("test read done");
  endtask
  // write cut short by select, then recovery
  task automatic t_abort();
    logic [7:0] rx;
    logic [14:0] n;
    n = wr_seen;
    i_master.sel();
    i_master.shift(8, 8'ha2, rx);
    i_master.shift(4, 8'haa, rx);
    i_master.desel();
    check("abort write", n, wr_seen);
    t_write(7'h7f, 8'h00);
    $display("test abort done");
  endtask
  // firmware load burst: every later byte is data for the load address
  task automatic t_fwload();
    logic [7:0] rx;
    logic [14:0] n;
    n = wr_seen;
    i_master.sel();
    i_master.shift(8, {`SSPS_DIR_WRITE, `SSPS_FW_LOAD_ADDR}, rx);
    i_master.shift(8, 8'h5a, rx);
    i_master.shift(8, 8'h95, rx);
    i_master.pause(20);
    check("load burst", 15'h0001, {14'h0000, burst});
    check("load count", n + 15'h0002, wr_seen);
    check("load word", {`SSPS_FW_LOAD_ADDR, 8'h95}, wr_last);
    i_master.desel();
    check("load end", 15'h0000, {14'h0000, burst});
    $display("test load done");
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (10) @(posedge ref_clk);
    t_gated();
    t_write(7'h15, 8'hc3);
    t_read(7'h2a, 5000, 1, 1'h0);
    t_abort();
    t_read(`SSPS_MOTION_BURST_ADDR, 7500, 3, 1'h1);
    t_read(`SSPS_PIXEL_BURST_ADDR, 5000, 2, 1'h1);
    t_fwload();
    conclude();
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
endmodule
